// ===== hw/slp_pkg.sv
`default_nettype none
package slp_pkg;
    localparam int unsigned APB_AW = 10;
    localparam int unsigned DW = 32;
    localparam int unsigned RW = 8;
    localparam int unsigned NPER = 8;
    localparam int unsigned CNT_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_SLEEP_CTRL = 8'h33;
    localparam logic [7:0] IDX_CLK_GATE = 8'h64;
    localparam logic [7:0] IDX_STATUS = 8'h35;
    localparam logic [APB_AW-1:0] ADDR_SLEEP_CTRL = {IDX_SLEEP_CTRL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CLK_GATE = {IDX_CLK_GATE, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

    localparam logic [RW-1:0] RST_SLEEP_CTRL = 8'h00;
    localparam logic [RW-1:0] RST_CLK_GATE = 8'h00;
    localparam logic [RW-1:0] CTRL_WMASK = 8'h0f;
    localparam int unsigned SE_BIT = 0;
    localparam int unsigned SM_LSB = 1;
    localparam int unsigned SM_MSB = 3;
    localparam int unsigned ST_SLEEP_BIT = 0;
    localparam int unsigned ST_MODE_LSB = 1;
    localparam int unsigned ST_MODE_MSB = 3;
    localparam int unsigned ST_WAKE_BIT = 4;

    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;

    // Wake delays in clock cycles
    localparam logic [CNT_W-1:0] WAKE_IDLE_CYC = 8'h01;
    localparam logic [CNT_W-1:0] WAKE_STBY_CYC = 8'h06;
    localparam logic [CNT_W-1:0] WAKE_OSC_CYC_DEF = 8'h10;

    // Clock enable vector positions
    localparam int unsigned CK_W = 5;
    localparam int unsigned CK_CPU = 4;
    localparam int unsigned CK_FLASH = 3;
    localparam int unsigned CK_IO = 2;
    localparam int unsigned CK_ASY = 1;
    localparam int unsigned CK_OSC = 0;
    localparam logic [CK_W-1:0] CK_ALL = 5'h1f;
    localparam logic [CK_W-1:0] CK_IDLE = 5'h07;
    localparam logic [CK_W-1:0] CK_NONE = 5'h00;
    localparam logic [CK_W-1:0] CK_PSAVE = 5'h02;
    localparam logic [CK_W-1:0] CK_STBY = 5'h01;
    localparam logic [CK_W-1:0] CK_XSTBY = 5'h03;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} slp_state_type;
endpackage
`default_nettype wire

// ===== hw/slp_wake_if.sv
`timescale 1ns/100ps
`default_nettype none
interface slp_wake_if;
    import slp_pkg::*;
    logic start;
    logic [CNT_W-1:0] load;
    logic busy;
    logic done;
    modport ctrl (output start, output load, input busy, input done);
    modport tmr (input start, input load, output busy, output done);
endinterface
`default_nettype wire

// ===== hw/slp_wake_timer.sv
`timescale 1ns/100ps
`default_nettype none
module slp_wake_timer (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    slp_wake_if.tmr w
);
    import slp_pkg::*;

    logic [CNT_W-1:0] cnt_reg;

    // Loads the delay, counts down; done marks the last waiting cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else if (w.start) begin
            cnt_reg <= w.load;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign w.busy = (cnt_reg != '0);
    assign w.done = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ===== hw/slp_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module slp_ctrl #(
    parameter logic [slp_pkg::CNT_W-1:0] WAKE_OSC_CYC = slp_pkg::WAKE_OSC_CYC_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [slp_pkg::APB_AW-1:0] i_paddr,
    input wire logic [slp_pkg::DW-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [slp_pkg::DW-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sleep_instr,
    input wire logic i_irq,
    input wire logic i_wake_pin,
    input wire logic [slp_pkg::NPER-1:0] i_io_sel,
    output logic [slp_pkg::NPER-1:0] o_io_sel_ok,
    output logic [slp_pkg::NPER-1:0] o_periph_clk_en,
    output logic o_cpu_clk_en,
    output logic o_flash_clk_en,
    output logic o_io_clk_en,
    output logic o_asy_clk_en,
    output logic o_osc_en,
    output logic o_sleeping
);
    import slp_pkg::*;

    typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_GATE, SEL_STAT} slp_sel_type;

    function automatic slp_sel_type reg_decode(input logic [APB_AW-1:0] addr);
        case (addr)
            ADDR_SLEEP_CTRL: reg_decode = SEL_CTRL;
            ADDR_CLK_GATE: reg_decode = SEL_GATE;
            ADDR_STATUS: reg_decode = SEL_STAT;
            default: reg_decode = SEL_NONE;
        endcase
    endfunction

    function automatic logic mode_valid(input logic [2:0] m);
        case (m)
            MODE_IDLE, MODE_PDOWN, MODE_PSAVE, MODE_STBY, MODE_XSTBY: mode_valid = 1'b1;
            default: mode_valid = 1'b0;
        endcase
    endfunction

    function automatic logic [CK_W-1:0] mode_clocks(input logic [2:0] m);
        case (m)
            MODE_IDLE: mode_clocks = CK_IDLE;
            MODE_PSAVE: mode_clocks = CK_PSAVE;
            MODE_STBY: mode_clocks = CK_STBY;
            MODE_XSTBY: mode_clocks = CK_XSTBY;
            default: mode_clocks = CK_NONE;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] wake_delay(input logic [2:0] m,
                                                    input logic [CNT_W-1:0] osc_cyc);
        case (m)
            MODE_IDLE: wake_delay = WAKE_IDLE_CYC;
            MODE_STBY, MODE_XSTBY: wake_delay = WAKE_STBY_CYC;
            default: wake_delay = osc_cyc;
        endcase
    endfunction

    logic [RW-1:0] ctrl_reg;
    logic [RW-1:0] gate_reg;
    logic [RW-1:0] gate_next;
    logic [2:0] mode_reg;
    slp_state_type state_reg;
    slp_state_type state_next;
    logic [CK_W-1:0] ck_reg;
    logic [CK_W-1:0] ck_next;
    logic [NPER-1:0] periph_en_reg;
    logic [NPER-1:0] io_ok_reg;
    logic [DW-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic wake_meta_reg;
    logic wake_sync_reg;
    logic apb_setup;
    logic apb_access;
    logic apb_wr;
    slp_sel_type sel_setup;
    slp_sel_type sel_acc;
    logic [RW-1:0] status_val;
    logic sleep_go;
    logic wake_evt;

    slp_wake_if wk ();

    slp_wake_timer u_wake_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .w(wk.tmr)
    );

    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable & pready_reg;
    assign apb_wr = apb_access & i_pwrite & i_pstrb[0];
    assign sel_setup = reg_decode(i_paddr);
    assign sel_acc = reg_decode(i_paddr);

    // Wake pin comes from outside the clock domain
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= i_wake_pin;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // Sleep control register: upper nibble never stored
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= RST_SLEEP_CTRL;
        end else if (apb_wr && sel_acc == SEL_CTRL) begin
            ctrl_reg <= i_pwdata[RW-1:0] & CTRL_WMASK;
        end
    end

    always_comb begin
        gate_next = gate_reg;
        if (apb_wr && sel_acc == SEL_GATE) begin
            gate_next = i_pwdata[RW-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_reg <= RST_CLK_GATE;
        end else begin
            gate_reg <= gate_next;
        end
    end

    // Sleep entry needs the permit bit and a defined mode code
    assign sleep_go = i_sleep_instr & ctrl_reg[SE_BIT]
                      & mode_valid(ctrl_reg[SM_MSB:SM_LSB]);

    // Idle also wakes on any pending interrupt from running peripherals
    assign wake_evt = wake_sync_reg | ((mode_reg == MODE_IDLE) & i_irq);

    always_comb begin
        state_next = state_reg;
        wk.start = 1'b0;
        wk.load = wake_delay(mode_reg, WAKE_OSC_CYC);
        case (state_reg)
            ST_RUN: begin
                if (sleep_go) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_evt) begin
                    state_next = ST_WAKE;
                    wk.start = 1'b1;
                end
            end
            ST_WAKE: begin
                if (wk.done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Mode in effect is latched at entry
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= MODE_IDLE;
        end else if (state_reg == ST_RUN && sleep_go) begin
            mode_reg <= ctrl_reg[SM_MSB:SM_LSB];
        end
    end

    // During wake-up the clocks of the sleep mode stay, plus the oscillator
    always_comb begin
        case (state_next)
            ST_RUN: ck_next = CK_ALL;
            ST_SLEEP: begin
                if (state_reg == ST_RUN) begin
                    ck_next = mode_clocks(ctrl_reg[SM_MSB:SM_LSB]);
                end else begin
                    ck_next = mode_clocks(mode_reg);
                end
            end
            ST_WAKE: begin
                ck_next = mode_clocks(mode_reg);
                ck_next[CK_OSC] = 1'b1;
            end
            default: ck_next = CK_ALL;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_reg <= CK_ALL;
        end else begin
            ck_reg <= ck_next;
        end
    end

    // Per-peripheral clock enables and access gating
    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi++) begin : g_periph
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    periph_en_reg[gi] <= 1'b1;
                    io_ok_reg[gi] <= 1'b0;
                end else begin
                    periph_en_reg[gi] <= ~gate_next[gi] & ck_next[CK_IO];
                    io_ok_reg[gi] <= i_io_sel[gi] & ~gate_reg[gi] & ck_reg[CK_IO];
                end
            end
        end
    endgenerate

    assign status_val = {3'h0, wk.busy, mode_reg, (state_reg != ST_RUN)};

    // APB slave: data and error prepared in setup, ready in the access phase
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (apb_setup) begin
            pready_reg <= 1'b1;
            pslverr_reg <= (sel_setup == SEL_NONE);
            prdata_reg <= '0;
            if (!i_pwrite) begin
                case (sel_setup)
                    SEL_CTRL: prdata_reg <= {{(DW-RW){1'b0}}, ctrl_reg};
                    SEL_GATE: prdata_reg <= {{(DW-RW){1'b0}}, gate_reg};
                    SEL_STAT: prdata_reg <= {{(DW-RW){1'b0}}, status_val};
                    default: prdata_reg <= '0;
                endcase
            end
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_io_sel_ok = io_ok_reg;
    assign o_periph_clk_en = periph_en_reg;
    assign o_cpu_clk_en = ck_reg[CK_CPU];
    assign o_flash_clk_en = ck_reg[CK_FLASH];
    assign o_io_clk_en = ck_reg[CK_IO];
    assign o_asy_clk_en = ck_reg[CK_ASY];
    assign o_osc_en = ck_reg[CK_OSC];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sleeping <= 1'b0;
        end else begin
            o_sleeping <= (state_next != ST_RUN);
        end
    end
endmodule
`default_nettype wire

// ===== bench/slp_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module slp_ctrl_asserts (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [slp_pkg::APB_AW-1:0] i_paddr,
    input wire logic [slp_pkg::DW-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [slp_pkg::DW-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic i_sleep_instr,
    input wire logic i_wake_pin,
    input wire logic [slp_pkg::NPER-1:0] i_io_sel,
    input wire logic [slp_pkg::NPER-1:0] o_io_sel_ok,
    input wire logic [slp_pkg::NPER-1:0] o_periph_clk_en,
    input wire logic o_cpu_clk_en,
    input wire logic o_io_clk_en,
    input wire logic o_osc_en,
    input wire logic o_sleeping
);
    import slp_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [3:0] ctrl;
    logic [2:0] mode;
    logic wr_ok;
    logic go;
    assign wr_ok = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
    assign go = i_sleep_instr && !o_sleeping;
    // Shadow of the control register and of the mode held at sleep entry
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl <= 4'h0;
        end else if (wr_ok && i_paddr == ADDR_SLEEP_CTRL) begin
            ctrl <= i_pwdata[3:0];
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode <= 3'h0;
        end else if (!o_sleeping) begin
            mode <= ctrl[3:1];
        end
    end
    property p_gate;
        wr_ok && i_paddr == ADDR_CLK_GATE && !o_sleeping && !go
            |=> o_periph_clk_en == ~$past(i_pwdata[7:0]);
    endproperty
    a_gate: assert property (p_gate) else $error("gate write not applied");
    property p_sel;
        !$past(i_rst) |-> o_io_sel_ok == ($past(i_io_sel) & $past(o_periph_clk_en));
    endproperty
    a_sel: assert property (p_sel) else $error("gated select passed");
    property p_rd;
        o_pready && !i_pwrite && i_paddr == ADDR_SLEEP_CTRL |-> o_prdata == {28'h0, ctrl};
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    property p_ready;
        i_psel && !i_penable |=> o_pready ##1 !o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle");
    property p_permit;
        go && !ctrl[0] |=> !o_sleeping;
    endproperty
    a_permit: assert property (p_permit) else $error("slept without permit");
    property p_resv;
        go && ctrl[0] && ctrl[3:1] inside {3'h1, 3'h4, 3'h5} |=> !o_sleeping;
    endproperty
    a_resv: assert property (p_resv) else $error("slept on reserved code");
    property p_idle;
        go && ctrl == 4'h1 |=> o_sleeping && !o_cpu_clk_en && o_io_clk_en && o_osc_en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle clocks wrong");
    property p_stby;
        $rose(i_wake_pin) && o_sleeping && mode[2:1] == 2'b11
            |-> o_sleeping [*8] ##[1:2] !o_sleeping;
    endproperty
    a_stby: assert property (p_stby) else $error("standby wake late");
    c_idle: cover property (go && ctrl == 4'h1);
    c_stby: cover property (go && ctrl == 4'hd);
    c_gate: cover property (wr_ok && i_paddr == ADDR_CLK_GATE);
endmodule
`default_nettype wire

// ===== bench/test_sleep_and_clock_gating_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_sleep_and_clock_gating_control;
    import slp_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic i_sleep_instr = 1'b0;
    logic i_irq = 1'b0;
    logic i_wake_pin = 1'b0;
    logic [3:0] i_pstrb = 4'h1;
    logic [APB_AW-1:0] i_paddr = '0;
    logic [DW-1:0] i_pwdata = '0;
    logic [NPER-1:0] i_io_sel = '0;
    logic [DW-1:0] o_prdata;
    logic [DW-1:0] rd;
    logic o_pready, o_pslverr, o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, err;
    logic o_asy_clk_en, o_osc_en, o_sleeping;
    logic [NPER-1:0] o_io_sel_ok, o_periph_clk_en;
    logic [3:0] cs [9] = '{4'h1, 4'h5, 4'h7, 4'hd, 4'hf, 4'h0, 4'h3, 4'h9, 4'hb};
    logic [4:0] ks [9] = '{5'h07, 5'h00, 5'h02, 5'h01, 5'h03, 5'h1f, 5'h1f, 5'h1f, 5'h1f};
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;

    slp_ctrl #(.WAKE_OSC_CYC(8'h02)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_sleep_instr(i_sleep_instr), .i_irq(i_irq), .i_wake_pin(i_wake_pin),
        .i_io_sel(i_io_sel), .o_io_sel_ok(o_io_sel_ok), .o_periph_clk_en(o_periph_clk_en),
        .o_cpu_clk_en(o_cpu_clk_en), .o_flash_clk_en(o_flash_clk_en),
        .o_io_clk_en(o_io_clk_en), .o_asy_clk_en(o_asy_clk_en), .o_osc_en(o_osc_en),
        .o_sleeping(o_sleeping));

    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // Entered just after a rising edge; leaves one idle edge after the access
    task apb(input logic w, input logic [APB_AW-1:0] a, input logic [DW-1:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task t_regs;
        @(posedge i_sys_clk);
        apb(1'b0, ADDR_SLEEP_CTRL, '0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, ADDR_SLEEP_CTRL, 32'hffff_fffe);
        apb(1'b0, ADDR_SLEEP_CTRL, '0);
        chk(rd, 32'h0000_000e);
        i_pstrb <= 4'h0;
        apb(1'b1, ADDR_SLEEP_CTRL, 32'h0000_0001);
        i_pstrb <= 4'h1;
        apb(1'b0, ADDR_SLEEP_CTRL, '0);
        chk(rd, 32'h0000_000e);
        apb(1'b0, 10'h3fc, '0);
        chk({rd[30:0], err}, 32'h0000_0001);
    endtask

    task t_gate;
        i_io_sel <= 8'hff;
        // Software side: the gated peripherals are taken as already idle
        apb(1'b1, ADDR_CLK_GATE, 32'h0000_00a5);
        #1;
        chk(o_periph_clk_en, 32'h0000_005a);
        chk(o_io_sel_ok, 32'h0000_005a);
        @(posedge i_sys_clk);
        apb(1'b0, ADDR_CLK_GATE, '0);
        chk(rd, 32'h0000_00a5);
        apb(1'b1, ADDR_CLK_GATE, 32'h0000_0000);
        #1;
        chk(o_periph_clk_en, 32'h0000_00ff);
        chk(o_io_sel_ok, 32'h0000_00ff);
    endtask

    task nap(input logic [3:0] c, input logic [4:0] ck);
        int n;
        @(posedge i_sys_clk);
        apb(1'b1, ADDR_SLEEP_CTRL, {28'h0, c});
        i_sleep_instr <= 1'b1;
        @(posedge i_sys_clk);
        i_sleep_instr <= 1'b0;
        #1;
        chk({o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_asy_clk_en, o_osc_en}, ck);
        chk(o_periph_clk_en, ck[2] ? 8'hff : 8'h00);
        chk(o_sleeping, ck != 5'h1f);
        @(posedge i_sys_clk);
        apb(1'b0, ADDR_STATUS, '0);
        chk({rd[31:4], rd[0]}, {28'h0, ck != 5'h1f});
        if (ck != 5'h1f) begin
            chk(rd[3:1], c[3:1]);
            @(posedge i_sys_clk);
            i_irq <= 1'b1;
            repeat (2) @(posedge i_sys_clk);
            #1;
            // A pending interrupt ends Idle only
            chk(o_sleeping, c[3:1] != MODE_IDLE);
            @(posedge i_sys_clk);
            i_irq <= 1'b0;
            i_wake_pin <= 1'b1;
            n = 0;
            do begin
                @(posedge i_sys_clk);
                #1;
                n++;
            end while (o_sleeping !== 1'b0 && n < 40);
            if (c[3:2] == 2'b11) begin
                chk(n <= 9, 1'b1);
            end
            @(posedge i_sys_clk);
            i_wake_pin <= 1'b0;
            #1;
            chk({o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_asy_clk_en, o_osc_en}, 5'h1f);
        end
    endtask

    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_regs();
        t_gate();
        for (int i = 0; i < 9; i++) begin
            nap(cs[i], ks[i]);
        end
        conclude();
    end
endmodule

bind slp_ctrl slp_ctrl_asserts u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .i_sleep_instr(i_sleep_instr),
    .i_wake_pin(i_wake_pin), .i_io_sel(i_io_sel), .o_io_sel_ok(o_io_sel_ok),
    .o_periph_clk_en(o_periph_clk_en), .o_cpu_clk_en(o_cpu_clk_en),
    .o_io_clk_en(o_io_clk_en), .o_osc_en(o_osc_en), .o_sleeping(o_sleeping));
`default_nettype wire
